/* verilog/scc_pkg.sv */
// Shared constants, types and helpers for six-channel conversion control
// How it works
// [RULE_01] Span per pair: range pin or span bits
// [RULE_02] Reference level bit picks 2.5 V or 3 V
// [RULE_03] Range pin caught as active-high busy falls
// [RULE_04] Conversion time bounded by both clock sources
// [RULE_05] Internal clock default; external only in software
// [RULE_06] Every conversion spans 18.5 conversion clock cycles
// [RULE_07] External clock may idle low between conversions
// [RULE_08] External clock kept near 50 percent duty
// [RULE_09] Pair inputs held on its strobe rising edge
// [RULE_10] Software non-sequential: first strobe starts all pairs
// [RULE_11] Conversion starts at next conversion clock edge
// [RULE_12] No new strobe to a converting pair
// [RULE_13] Busy rises on strobe, falls after last load
// [RULE_14] Host may read right after busy falls
// [RULE_15] Sequential mode: busy low one cycle between
// [RULE_16] Interrupt mode: output high on completion
// [RULE_17] Polarity bit inverts the busy/interrupt output
// [RULE_18] Reference DAC: range times code plus one
// [RULE_19] Software avoids DAC output below 0.5 V
// [RULE_20] Internal reference powered down by default
// [RULE_21] Reference buffers may be powered down
// [RULE_22] Select low: hardware mode, pins plus subset
// [RULE_23] Reset: busy off, internal clock, pairs idle
`default_nettype none
package scc_pkg;
    localparam int NUM_PAIRS = 3;
    localparam int CW_W = 32;
    localparam int DAC_W = 10;
    localparam int DAC_LSB = 0;
    localparam int CLK_SRC_BIT = 11;
    localparam int SEQ_MODE_BIT = 12;
    localparam int BUF_PD_BIT = 14;
    localparam int REF_PU_BIT = 15;
    localparam int REF_LEVEL_BIT = 18;
    localparam int BUSY_POL_BIT = 20;
    localparam int INT_MODE_BIT = 21;
    localparam int SPAN_LSB = 24;
    localparam logic [CW_W-1:0] CW_RESET = 32'h0000_0000;
    // Hardware mode honours only C[22:18], C[15:13] and C[9:0]
    localparam logic [CW_W-1:0] HW_MASK = 32'h007C_E3FF;
    // 18.5 conversion clock cycles counted as half periods
    localparam int CONV_HALF = 37;
    localparam int CLK_HZ = 40_000_000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int CONV_TIME_NS = 1260;
    localparam int EXT_CLK_MAX_HZ = 20_000_000;
    localparam int INT_HALF_RAW = CONV_TIME_NS / (CLK_PERIOD_NS * CONV_HALF);
    localparam int INT_HALF_CYC = (INT_HALF_RAW < 1) ? 1 : INT_HALF_RAW;
    localparam int EXT_HALF_CYC = (CLK_HZ + 2 * EXT_CLK_MAX_HZ - 1)
                                  / (2 * EXT_CLK_MAX_HZ);
    localparam int DIV_W = 4;
    localparam int VREF_W = 12;
    localparam int REF_LOW_MV = 2500;
    localparam int REF_HIGH_MV = 3000;
    localparam int DAC_FULL = 1024;
    localparam int DAC_MIN_MV = 500;
    localparam int ADDR_W = 2;
    localparam logic [ADDR_W-1:0] REG_CMD = 2'h0;
    localparam logic [ADDR_W-1:0] REG_CTRL = 2'h1;
    localparam logic [ADDR_W-1:0] REG_STAT = 2'h2;
    localparam logic [ADDR_W-1:0] REG_CFG = 2'h3;
    localparam int CFG_SW_BIT = 0;
    localparam int CFG_RANGE_BIT = 1;
    localparam int CFG_EXT_BIT = 2;
    localparam int CFG_POL_BIT = 3;
    localparam int CFG_W = 4;

    typedef enum logic [1:0] {PAIR_IDLE, PAIR_ARMED, PAIR_CONV} scc_pair_st_t;

    function automatic logic [23:0] scc_range_mv(input logic lvl);
        return lvl ? 24'(REF_HIGH_MV) : 24'(REF_LOW_MV);
    endfunction : scc_range_mv

    function automatic logic [VREF_W-1:0] scc_vref_mv(
        input logic [DAC_W-1:0] code, input logic lvl);
        logic [23:0] p;
        p = scc_range_mv(lvl) * (24'(code) + 24'h1);
        return VREF_W'(p / 24'(DAC_FULL));
    endfunction : scc_vref_mv

    function automatic logic [DAC_W-1:0] scc_dac_min(input logic lvl);
        logic [23:0] r;
        r = scc_range_mv(lvl);
        return DAC_W'((24'(DAC_MIN_MV) * 24'(DAC_FULL) + r - 24'h1) / r
                      - 24'h1);
    endfunction : scc_dac_min
endpackage : scc_pkg
`default_nettype wire

/* verilog/scc_link_if.sv */
// Pin-level link between the host controller and the converter control
`default_nettype none
interface scc_link_if;
    logic [scc_pkg::NUM_PAIRS-1:0] strobe;
    logic ext_clk;
    logic cfg_sw;
    logic range_pin;
    logic [scc_pkg::CW_W-1:0] ctrl_word;
    logic ctrl_load;
    logic busy_int;
    modport dev (
        input strobe, ext_clk, cfg_sw, range_pin, ctrl_word, ctrl_load,
        output busy_int
    );
    modport host (
        output strobe, ext_clk, cfg_sw, range_pin, ctrl_word, ctrl_load,
        input busy_int
    );
endinterface : scc_link_if
`default_nettype wire

/* verilog/scc_pair_conv.sv */
// One channel pair: sample, wait for clock edge, count the conversion
`default_nettype none
module scc_pair_conv #(
    parameter int HALF_EDGES = scc_pkg::CONV_HALF
) (
    input wire logic i_clk,       // System clock
    input wire logic i_reset_n,   // Async reset, active low
    input wire logic i_sample,    // Strobe rising edge, one cycle
    input wire logic i_conv_edge, // Conversion clock edge, one cycle
    output logic o_active,        // Pair armed or converting
    output logic o_load           // Result loaded, one cycle
);
    import scc_pkg::*;
    localparam int CW = $clog2(HALF_EDGES);
    localparam logic [CW-1:0] LAST = CW'(HALF_EDGES - 1);
    if (HALF_EDGES < 2) $error("HALF_EDGES must be at least 2");

    scc_pair_st_t state_ff;
    scc_pair_st_t nxt_state;
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    wire logic at_last = (cnt_ff == LAST);

    assign o_active = (state_ff != PAIR_IDLE);
    assign o_load = (state_ff == PAIR_CONV) && i_conv_edge && at_last;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            PAIR_IDLE:
            begin
                // A strobe while busy is not expected and is ignored
                if (i_sample)
                    nxt_state = PAIR_ARMED; // [RULE_09]
            end
            PAIR_ARMED:
            begin
                if (i_conv_edge)
                begin
                    nxt_state = PAIR_CONV; // [RULE_11]
                    nxt_cnt = '0;
                end
            end
            PAIR_CONV:
            begin
                if (i_conv_edge)
                begin
                    if (at_last)
                        nxt_state = PAIR_IDLE; // [RULE_06]
                    else
                        nxt_cnt = cnt_ff + CW'(1);
                end
            end
            default:
                nxt_state = PAIR_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_ff <= PAIR_IDLE; // [RULE_23]
            cnt_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end
endmodule : scc_pair_conv
`default_nettype wire

/* verilog/scc_device_end.sv */
// Converter-side conversion control: strobes, clocks, busy and reference
//
// Implementation choices: strobed register access and the address map.
`default_nettype none
module scc_device_end (
    input wire logic i_clk,                        // System clock
    input wire logic i_reset_n,                    // Async reset, active low
    scc_link_if.dev link,                          // Link to host
    output logic [scc_pkg::NUM_PAIRS-1:0] o_span,  // 1: four times ref span
    output logic o_ref_level,                      // 1: 3 V reference
    output logic [scc_pkg::DAC_W-1:0] o_dac_code,  // Reference DAC code
    output logic [scc_pkg::VREF_W-1:0] o_vref_mv,  // DAC output in mV
    output logic o_ref_drive,                      // Internal ref drives pin
    output logic [scc_pkg::NUM_PAIRS-1:0] o_buf_en, // Pair ref buffer on
    output logic o_clk_ext,                        // External clock in use
    output logic o_sw_mode,                        // Software mode
    output logic o_range_latched,                  // Caught range pin level
    output logic [scc_pkg::NUM_PAIRS-1:0] o_result_load // Result loaded
);
    import scc_pkg::*;
    if (INT_HALF_CYC > (1 << DIV_W)) $error("INT_HALF_CYC too large");

    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(INT_HALF_CYC - 1);

    logic [CW_W-1:0] cw_ff;
    logic [NUM_PAIRS-1:0] strobe_prev_ff;
    logic ext_prev_ff;
    logic [DIV_W-1:0] div_ff;
    logic busy_ff;
    logic int_ff;
    logic out_ff;
    logic range_ff;
    logic [NUM_PAIRS-1:0] span_ff;
    logic ref_level_ff;
    logic [DAC_W-1:0] dac_ff;
    logic [VREF_W-1:0] vref_ff;
    logic ref_drive_ff;
    logic [NUM_PAIRS-1:0] buf_en_ff;
    logic clk_ext_ff;
    logic sw_ff;
    logic [NUM_PAIRS-1:0] load_ff;

    wire logic sw_mode = link.cfg_sw;
    wire logic [CW_W-1:0] eff_cw = sw_mode ? cw_ff : (cw_ff & HW_MASK);
    wire logic seq_mode = sw_mode && eff_cw[SEQ_MODE_BIT];
    wire logic all_pairs = sw_mode && !seq_mode;
    wire logic busy_pol = eff_cw[BUSY_POL_BIT];
    wire logic int_mode = eff_cw[INT_MODE_BIT];
    wire logic ext_sel = sw_mode && eff_cw[CLK_SRC_BIT];
    wire logic [NUM_PAIRS-1:0] rise = link.strobe & ~strobe_prev_ff;
    wire logic [NUM_PAIRS-1:0] sample;
    wire logic ext_edge = link.ext_clk ^ ext_prev_ff;
    wire logic int_edge = (div_ff == DIV_LAST);
    wire logic conv_edge;
    wire logic [NUM_PAIRS-1:0] active;
    wire logic [NUM_PAIRS-1:0] load;
    wire logic any_sample = |sample;
    wire logic any_load = |load;
    wire logic any_left = |(active & ~load);
    wire logic all_done = any_load && !any_left;
    wire logic nxt_busy;
    wire logic nxt_int;
    wire logic nxt_level;
    wire logic busy_fall;
    wire logic [NUM_PAIRS-1:0] nxt_span;

    // Software mode without sequencing fans the first strobe out
    assign sample = all_pairs ? {NUM_PAIRS{rise[0]}} : rise; // [RULE_10]

    // Only edges are counted, so a clock held low simply stalls
    assign conv_edge = ext_sel ? ext_edge : int_edge; // [RULE_05] [RULE_07]

    // Sequencing drops busy for one cycle whenever a pair finishes early
    assign nxt_busy = any_sample // [RULE_13]
                    || (any_left && !(seq_mode && any_load)); // [RULE_15]

    // Completion sets the flag; a new strobe clears it, set wins
    assign nxt_int = all_done || (int_ff && !any_sample); // [RULE_16]

    assign nxt_level = int_mode ? nxt_int : nxt_busy;
    assign busy_fall = busy_ff && !nxt_busy && !busy_pol; // [RULE_03]

    assign nxt_span = sw_mode ? eff_cw[SPAN_LSB +: NUM_PAIRS]
                              : {NUM_PAIRS{range_ff}}; // [RULE_01]

    for (genvar p = 0; p < NUM_PAIRS; p++)
    begin : g_pair
        scc_pair_conv #(
            .HALF_EDGES(CONV_HALF)
        ) u_pair (
            .i_clk(i_clk),
            .i_reset_n(i_reset_n),
            .i_sample(sample[p]),
            .i_conv_edge(conv_edge),
            .o_active(active[p]),
            .o_load(load[p])
        );
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            cw_ff <= CW_RESET; // [RULE_20] [RULE_23]
        else if (link.ctrl_load)
            cw_ff <= link.ctrl_word;
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            strobe_prev_ff <= '0;
            ext_prev_ff <= 1'b0;
        end
        else
        begin
            strobe_prev_ff <= link.strobe; // [RULE_09]
            ext_prev_ff <= link.ext_clk;
        end
    end

    // Internal clock half period sized so 18.5 cycles fit in 1.26 us
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            div_ff <= '0;
        else if (int_edge)
            div_ff <= '0; // [RULE_04]
        else
            div_ff <= div_ff + DIV_W'(1);
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            busy_ff <= 1'b0;
            int_ff <= 1'b0;
            out_ff <= 1'b0; // [RULE_23]
        end
        else
        begin
            busy_ff <= nxt_busy;
            int_ff <= nxt_int;
            out_ff <= nxt_level ^ busy_pol; // [RULE_17]
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            range_ff <= 1'b0;
        else if (busy_fall)
            range_ff <= link.range_pin; // [RULE_03]
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            span_ff <= '0;
            ref_level_ff <= 1'b0;
            dac_ff <= '0;
            vref_ff <= '0;
            ref_drive_ff <= 1'b0;
            buf_en_ff <= '0;
            clk_ext_ff <= 1'b0;
            sw_ff <= 1'b0;
            load_ff <= '0;
        end
        else
        begin
            span_ff <= nxt_span;
            ref_level_ff <= eff_cw[REF_LEVEL_BIT]; // [RULE_02]
            dac_ff <= eff_cw[DAC_LSB +: DAC_W];
            vref_ff <= scc_vref_mv(eff_cw[DAC_LSB +: DAC_W],
                                   eff_cw[REF_LEVEL_BIT]); // [RULE_18]
            ref_drive_ff <= eff_cw[REF_PU_BIT]; // [RULE_20]
            buf_en_ff <= {NUM_PAIRS{!eff_cw[BUF_PD_BIT]}}; // [RULE_21]
            clk_ext_ff <= ext_sel; // [RULE_05]
            sw_ff <= sw_mode; // [RULE_22]
            load_ff <= load;
        end
    end

    assign link.busy_int = out_ff;
    assign o_span = span_ff;
    assign o_ref_level = ref_level_ff;
    assign o_dac_code = dac_ff;
    assign o_vref_mv = vref_ff;
    assign o_ref_drive = ref_drive_ff;
    assign o_buf_en = buf_en_ff;
    assign o_clk_ext = clk_ext_ff;
    assign o_sw_mode = sw_ff;
    assign o_range_latched = range_ff;
    assign o_result_load = load_ff;
endmodule : scc_device_end
`default_nettype wire

/* verilog/scc_host_end.sv */
// Host-side controller: strobes, external clock and control word source
`default_nettype none
module scc_host_end (
    input wire logic i_clk,                       // System clock
    input wire logic i_reset_n,                   // Async reset, active low
    scc_link_if.host link,                        // Link to converter
    input wire logic [scc_pkg::ADDR_W-1:0] i_addr, // Register address
    input wire logic [scc_pkg::CW_W-1:0] i_wdata, // Write data
    input wire logic i_wr,                        // Write strobe
    input wire logic i_rd,                        // Read strobe
    output logic [scc_pkg::CW_W-1:0] o_rdata      // Read data, next cycle
);
    import scc_pkg::*;
    if (EXT_HALF_CYC > (1 << DIV_W)) $error("EXT_HALF_CYC too large");

    localparam logic [DIV_W-1:0] EXT_LAST = DIV_W'(EXT_HALF_CYC - 1);

    logic [CFG_W-1:0] cfg_ff;
    logic [CW_W-1:0] cw_ff;
    logic load_ff;
    logic [NUM_PAIRS-1:0] strobe_ff;
    logic [NUM_PAIRS-1:0] pend_ff;
    logic busy_prev_ff;
    logic fall_ff;
    logic external_conv_clock_ff;
    logic [DIV_W-1:0] div_ff;
    logic [CW_W-1:0] rdata_ff;

    wire logic wr_cmd = i_wr && (i_addr == REG_CMD);
    wire logic wr_ctrl = i_wr && (i_addr == REG_CTRL);
    wire logic wr_cfg = i_wr && (i_addr == REG_CFG);
    wire logic busy_act = link.busy_int ^ cfg_ff[CFG_POL_BIT];
    wire logic busy_fall = busy_prev_ff && !busy_act; // [RULE_14]
    wire logic busy_rise = !busy_prev_ff && busy_act;
    // A lone low cycle is a sequential gap; later pairs still convert
    wire logic low_held = fall_ff && !busy_act; // [RULE_15]
    // In interrupt mode the output rises when the work is done
    wire logic work_done =
        cw_ff[INT_MODE_BIT] ? busy_rise : low_held; // [RULE_16]
    wire logic [NUM_PAIRS-1:0] req =
        wr_cmd ? (i_wdata[NUM_PAIRS-1:0] & ~pend_ff) : '0; // [RULE_12]
    wire logic [DAC_W-1:0] dac_min = scc_dac_min(i_wdata[REF_LEVEL_BIT]);
    wire logic [DAC_W-1:0] dac_req = i_wdata[DAC_LSB +: DAC_W];
    wire logic [DAC_W-1:0] dac_ok =
        (dac_req < dac_min) ? dac_min : dac_req; // [RULE_19]
    wire logic ext_run = cfg_ff[CFG_EXT_BIT] && (|pend_ff);
    wire logic ext_tick = (div_ff == EXT_LAST);
    wire logic [CW_W-1:0] rd_sel =
        (i_addr == REG_CMD)  ? CW_W'(pend_ff) :
        (i_addr == REG_CTRL) ? cw_ff :
        (i_addr == REG_STAT) ? CW_W'({busy_act, pend_ff}) :
                               CW_W'(cfg_ff);

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            cfg_ff <= '0;
            cw_ff <= CW_RESET;
            load_ff <= 1'b0;
        end
        else
        begin
            if (wr_cfg)
                cfg_ff <= i_wdata[CFG_W-1:0];
            if (wr_ctrl)
                cw_ff <= {i_wdata[CW_W-1:DAC_W], dac_ok};
            load_ff <= wr_ctrl;
        end
    end

    // Pending clears when busy ends; a request in that cycle still sets
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            strobe_ff <= '0;
            pend_ff <= '0;
            busy_prev_ff <= 1'b0;
            fall_ff <= 1'b0;
        end
        else
        begin
            strobe_ff <= req;
            pend_ff <= (pend_ff & ~{NUM_PAIRS{work_done}}) | req; // [RULE_12]
            busy_prev_ff <= busy_act;
            fall_ff <= busy_fall;
        end
    end

    // Toggling on a fixed count keeps the duty at half; idle is low
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            external_conv_clock_ff <= 1'b0;
            div_ff <= '0;
        end
        else if (!ext_run)
        begin
            external_conv_clock_ff <= 1'b0; // [RULE_07]
            div_ff <= '0;
        end
        else if (ext_tick)
        begin
            external_conv_clock_ff <= !external_conv_clock_ff; // [RULE_08]
            div_ff <= '0;
        end
        else
            div_ff <= div_ff + DIV_W'(1);
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            rdata_ff <= '0;
        else
            rdata_ff <= i_rd ? rd_sel : '0;
    end

    assign link.strobe = strobe_ff;
    assign link.ext_clk = external_conv_clock_ff;
    assign link.cfg_sw = cfg_ff[CFG_SW_BIT];
    assign link.range_pin = cfg_ff[CFG_RANGE_BIT];
    assign link.ctrl_word = cw_ff;
    assign link.ctrl_load = load_ff;
    assign o_rdata = rdata_ff;
endmodule : scc_host_end
`default_nettype wire

/* bench/scc_link_monitor.sv */
// Concurrent checks on the link between host and converter control
`default_nettype none
module scc_link_monitor (
    input wire logic i_clk,             // System clock
    input wire logic i_reset_n,         // Async reset, active low
    input wire logic [2:0] strobe,      // Pair sample strobes
    input wire logic ext_clk,           // External conversion clock
    input wire logic cfg_sw,            // Software mode
    input wire logic range_pin,         // Range pin level
    input wire logic [31:0] ctrl_word,  // Control word
    input wire logic ctrl_load,         // Control word load pulse
    input wire logic busy_int           // Busy or interrupt
);
    timeunit 1ns;
    timeprecision 1ps;
    import scc_pkg::*;
    logic [31:0] cw_ff;
    logic [2:0] q_ff;
    logic [2:0] prev_ff;
    logic [5:0] idle_ff;
    logic [5:0] len_ff;
    logic sw_ff;
    logic multi_ff;
    wire logic pol = cw_ff[BUSY_POL_BIT];
    wire logic act = busy_int ^ pol;
    wire logic intm = cw_ff[INT_MODE_BIT];
    wire logic seq = cfg_sw & cw_ff[SEQ_MODE_BIT];
    // Polarity and mode changes need a few cycles to reach busy_int
    wire logic quiet = q_ff >= 3'h3;
    wire logic rise_any = |(strobe & ~prev_ff);
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            cw_ff <= CW_RESET;
            q_ff <= 3'h0;
            prev_ff <= 3'h0;
            idle_ff <= 6'h00;
            len_ff <= 6'h00;
            sw_ff <= 1'b0;
            multi_ff <= 1'b0;
        end
        else
        begin
            if (ctrl_load)
                cw_ff <= ctrl_word;
            q_ff <= (ctrl_load || cfg_sw != sw_ff) ? 3'h0
                    : q_ff + {2'h0, ~&q_ff};
            sw_ff <= cfg_sw;
            prev_ff <= strobe;
            idle_ff <= |strobe ? 6'h00 : idle_ff + {5'h00, ~&idle_ff};
            len_ff <= act ? len_ff + {5'h00, ~&len_ff} : 6'h00;
            multi_ff <= act & (multi_ff | rise_any);
        end
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);
    sequence s_start;
        quiet && !intm && !act && $rose(strobe[0]);
    endsequence
    sequence s_conv_end;
        $fell(act) && quiet && !intm;
    endsequence
    a_busy_rise: assert property (s_start |-> ##[1:2] act)
        else $error("busy did not follow the strobe");
    a_conv_len: assert property (
        s_conv_end ##0 (!seq && !multi_ff) |->
        len_ff >= 6'h25 && len_ff <= 6'h32)
        else $error("conversion length out of bounds");
    a_seq_gap: assert property (
        s_conv_end ##0 (seq && multi_ff) |=> act)
        else $error("sequential busy gap longer than one cycle");
    a_idle_level: assert property (
        idle_ff == 6'h3F && quiet && !intm |-> busy_int == pol)
        else $error("idle busy level wrong");
    a_ext_idle: assert property (
        idle_ff == 6'h3F && !intm |-> !ext_clk)
        else $error("external clock running while idle");
    a_ext_duty: assert property (ext_clk |=> !ext_clk)
        else $error("external clock high phase too long");
    a_int_hold: assert property (
        intm && quiet && act && strobe == 3'h0 && prev_ff == 3'h0 |=> act)
        else $error("interrupt dropped without strobe");
    a_reset_idle: assert property (
        $rose(i_reset_n) |-> busy_int == 1'b0 && strobe == 3'h0)
        else $error("link not idle after reset");
endmodule : scc_link_monitor
`default_nettype wire

/* bench/tb.sv */
// Self-checking bench joining host and converter control ends
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import scc_pkg::*;
    logic i_clk, i_reset_n, i_wr, i_rd;
    logic [ADDR_W-1:0] i_addr;
    logic [CW_W-1:0] i_wdata, o_rdata, cw, rd_v;
    logic [NUM_PAIRS-1:0] o_span, o_buf_en, o_result_load;
    logic o_ref_level, o_ref_drive, o_clk_ext, o_sw_mode, o_range_latched;
    logic [DAC_W-1:0] o_dac_code, code;
    logic [VREF_W-1:0] o_vref_mv;
    logic [2:0] cm;
    int fails, checks_done, seed, cyc, lc[3], base[3];
    scc_link_if link ();
    scc_host_end scc_host_end_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .link(link), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata));
    scc_device_end scc_device_end_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .link(link), .o_span(o_span), .o_ref_level(o_ref_level),
        .o_dac_code(o_dac_code), .o_vref_mv(o_vref_mv),
        .o_ref_drive(o_ref_drive), .o_buf_en(o_buf_en),
        .o_clk_ext(o_clk_ext), .o_sw_mode(o_sw_mode),
        .o_range_latched(o_range_latched), .o_result_load(o_result_load));
    scc_link_monitor scc_link_monitor_i (.i_clk(i_clk),
        .i_reset_n(i_reset_n), .strobe(link.strobe), .ext_clk(link.ext_clk),
        .cfg_sw(link.cfg_sw), .range_pin(link.range_pin),
        .ctrl_word(link.ctrl_word), .ctrl_load(link.ctrl_load),
        .busy_int(link.busy_int));
    initial
    begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    task automatic results();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results
    // Load pulses counted per pair; a hang is cut at the ceiling
    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        for (int k = 0; k < 3; k++)
            lc[k] <= lc[k] + int'(o_result_load[k]);
        if (cyc == 5000)
        begin
            fails = fails + 1;
            results();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            fails = fails + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [1:0] a, input logic [31:0] d, input int n);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        repeat (n) @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] a);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 rd_v = o_rdata;
    endtask : rd
    function automatic logic [9:0] f_code(input logic [9:0] c, input logic l);
        logic [9:0] m;
        m = l ? 10'h0AA : 10'h0CC;
        return (c < m) ? m : c;
    endfunction : f_code
    function automatic logic [11:0] f_vref(input logic [9:0] c, input logic l);
        return 12'(((l ? REF_HIGH_MV : REF_LOW_MV) * (int'(c) + 1))
                   / DAC_FULL);
    endfunction : f_vref
    task automatic setup(input logic [3:0] c, input logic [31:0] w);
        wr(REG_CFG, {28'h0, c}, 1);
        wr(REG_CTRL, w, 1);
        repeat (5) @(posedge i_clk);
    endtask : setup
    // A mid value of zero skips the status checks and the final status read
    task automatic conv(input logic [2:0] c, input logic [2:0] exp,
                        input logic [3:0] mid, input int n);
        for (int k = 0; k < 3; k++)
            base[k] = lc[k];
        wr(REG_CMD, 32'(c), n);
        repeat (4) @(posedge i_clk);
        rd(REG_STAT);
        if (mid != 4'h0)
            chk(rd_v, 32'(mid));
        // Longest conversion is about 39 cycles
        repeat (60) @(posedge i_clk);
        for (int k = 0; k < 3; k++)
            chk(32'(lc[k] - base[k]), 32'(exp[k]));
        if (mid != 4'h0)
            rd(REG_STAT);
        if (mid != 4'h0)
            chk(rd_v, 32'h0);
    endtask : conv
    initial
    begin
        i_reset_n = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 2'h0;
        i_wdata = 32'h0;
        fails = 0;
        checks_done = 0;
        seed = 76824;
        cyc = 0;
        lc = '{0, 0, 0};
        repeat (12) @(posedge i_clk);
        i_reset_n <= 1'b1;
        @(posedge i_clk);
        #1;
        chk(32'({o_span, o_ref_drive}), 32'h0);
        chk(32'({o_clk_ext, link.busy_int}), 32'h0);
        for (int i = 0; i < 6; i++)
        begin
            cw = $random(seed);
            cw[SEQ_MODE_BIT] = 1'b0;
            cw[INT_MODE_BIT] = 1'b0;
            if (i == 0)
                cw[9:0] = 10'h000;
            if (i == 1)
                cw[9:0] = 10'h3FF;
            if (i == 2)
                cw[CLK_SRC_BIT] = 1'b1;
            if (i == 3)
                cw[BUSY_POL_BIT] = 1'b1;
            code = f_code(cw[9:0], cw[18]);
            setup({cw[BUSY_POL_BIT], cw[CLK_SRC_BIT], 2'h1}, cw);
            chk(32'(o_span), 32'(cw[26:24]));
            chk(32'(o_ref_level), 32'(cw[18]));
            chk(32'(o_dac_code), 32'(code));
            chk(32'(o_vref_mv), 32'(f_vref(code, cw[18])));
            chk(32'(o_ref_drive), 32'(cw[15]));
            chk(32'(o_buf_en), 32'({3{~cw[14]}}));
            chk(32'({o_clk_ext, o_sw_mode}), 32'({cw[11], 1'b1}));
            cm = 3'($random(seed)) | 3'h1;
            conv(cm, 3'h7, {1'b1, cm}, 1);
        end
        // Hardware mode ignores span and clock source bits
        setup(4'h2, 32'h0700_092C);
        chk(32'({o_clk_ext, o_sw_mode}), 32'h0);
        chk(32'(o_dac_code), 32'h12C);
        conv(3'h3, 3'h3, 4'hB, 1);
        chk(32'({o_range_latched, o_span}), 32'hF);
        setup(4'h8, 32'h0010_092C);
        conv(3'h1, 3'h1, 4'h9, 1);
        chk(32'({o_range_latched, o_span}), 32'hF);
        setup(4'h0, 32'h0000_092C);
        conv(3'h1, 3'h1, 4'h9, 1);
        chk(32'({o_range_latched, o_span}), 32'h0);
        // Sequential run on the external clock must not stall in the gap
        setup(4'h5, 32'h0000_1A00);
        wr(REG_CMD, 32'h1, 1);
        repeat (10) @(posedge i_clk);
        conv(3'h2, 3'h3, 4'hB, 1);
        // Second back-to-back start hits a pending pair
        setup(4'h1, 32'h0020_0200);
        conv(3'h1, 3'h7, 4'h0, 2);
        chk(32'(link.busy_int), 32'h1);
        results();
    end
endmodule : tb
`default_nettype wire
